/* verilog/rcl_reset_config_latch.sv */
`timescale 1ns/1ps
// Contract
// - Reference strap is sampled when a full reset is released.
// - Latched reference strap 1 enables internal reference, 0 needs external.
// - Later reference strap changes are ignored until the next full reset.
// - Latched configuration changes only through a full reset.
// - Hardware mode reads checksum, burst and sequencer straps after full reset.
// - Burst and sequencer straps latch only in hardware mode, then ignored.
// - Mode, reference and interface straps latch at full reset in both modes.
// - Hardware mode reads channel pair pins at any reset release.
// - Range pins act at once; host allows about 120 us settling.
// - Hardware mode honours range pins always; pair and range never latched.
// - Mode selection changes only through a full reset.
// - Hardware mode refuses every register access.
// - Software mode takes all other configuration from registers; code uses only the range and pair register bits.
// - Low pulse of 40 ns to 500 ns is a partial reset; code takes any pulse from 40 ns up to 1.2 us as partial.
// - Device is ready 120 ns after a partial reset release.
// - Low pulse of at least 1.2 us is a full reset.
// - Device is ready 15 ms after a full reset release.
// - Partial reset reinitialises sequencer, filter, converters, drops result.
// - Partial reset keeps register contents and latched configuration.
// - Full reset returns everything to power-on defaults.
// - Range strap 00 at full release selects software mode, else hardware.
module rcl_reset_config_latch
   import rcl_pkg::*;
#(
   parameter int FULL_READY_CYCLES   = FULL_READY_CYC,
   parameter int RANGE_SETTLE_CYCLES = RANGE_SETTLE_CYC
) (
   input  wire logic              clk_sys_i,          // System clock, 50 MHz.
   input  wire logic              reset_i,            // Synchronous power-on reset.
   input  wire logic              reset_pin_n_i,      // Reset pin, active low.
   input  wire logic              ref_select_strap_i, // Reference select strap.
   input  wire logic [1:0]        range_mode_strap_i, // Range and mode strap.
   input  wire logic              iface_type_strap_i, // Interface type strap.
   input  wire logic              crc_strap_i,        // Checksum enable strap.
   input  wire logic              wr_burst_i,         // Burst strap in hardware mode.
   input  wire logic              seq_enable_strap_i, // Sequencer enable strap.
   input  wire logic [2:0]        pair_select_pins_i, // Channel pair select pins.
   input  wire logic              conv_start_i,       // Conversion start pin.
   input  wire logic [ADDR_W-1:0] reg_addr_i,         // Register address.
   input  wire logic [DATA_W-1:0] reg_wdata_i,        // Register write data.
   input  wire logic              reg_wr_i,           // Register write strobe.
   input  wire logic              reg_rd_i,           // Register read strobe.
   output logic      [DATA_W-1:0] reg_rdata_o,        // Read data, cycle after read.
   output logic                   reg_refused_o,      // Access refused pulse.
   output rcl_cfg_t               cfg_o,              // Latched configuration.
   output logic      [1:0]        range_o,            // Active input range.
   output logic                   range_settled_o,    // Range settling elapsed.
   output logic      [2:0]        pair_sel_o,         // Channel pair in use.
   output logic                   reinit_o,           // Sequencer, filter, ADC reinit.
   output logic                   ready_o,            // Device may start conversion.
   output logic                   busy_o,             // Conversion in progress.
   output logic                   result_valid_o      // Conversion result kept.
);

   // ------------------------------------------------------------
   // Pin synchronisers.
   // ------------------------------------------------------------
   localparam int SYNC_W = 12;
   // The reset pin idles high; clearing its flops to zero would fake a short
   // low pulse after power-on and trigger a spurious partial reset.
   localparam logic [SYNC_W-1:0] SYNC_IDLE = 12'h800;

   logic [SYNC_W-1:0] pins_m;
   logic [SYNC_W-1:0] pins_s;
   logic              conv_d;
   logic              pin_rst_n;
   logic              ref_s;
   logic [1:0]        range_s;
   logic              iface_s;
   logic              crc_s;
   logic              burst_s;
   logic              seq_s;
   logic [2:0]        pair_s;
   logic              conv_s;

   // Every pin is asynchronous to the clock, so each passes two flops.
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         pins_m <= SYNC_IDLE;
         pins_s <= SYNC_IDLE;
      end else begin
         pins_m <= {reset_pin_n_i, ref_select_strap_i, range_mode_strap_i,
                    iface_type_strap_i, crc_strap_i, wr_burst_i, seq_enable_strap_i,
                    pair_select_pins_i, conv_start_i};
         pins_s <= pins_m;
      end
   end

   assign {pin_rst_n, ref_s, range_s, iface_s, crc_s, burst_s, seq_s, pair_s,
           conv_s} = pins_s;

   // ------------------------------------------------------------
   // Reset pulse classification.
   // ------------------------------------------------------------
   rcl_state_t       state;
   logic [LOW_W-1:0] low_cnt;
   logic [CNT_W-1:0] wait_cnt;
   logic             release_now;
   logic             full_rel;
   logic             part_rel;
   logic             full_hold;

   assign release_now = (state == ST_LOW) && pin_rst_n;
   assign full_rel    = release_now && (low_cnt >= LOW_W'(FULL_MIN_CYC));
   // Pulses above the partial limit but short of full still count as partial.
   assign part_rel    = release_now && !full_rel &&
                        (low_cnt >= LOW_W'(PART_MIN_CYC));
   // Only while the pin is still low: in the release cycle the latches must load,
   // not clear, or a full reset would never capture its straps.
   assign full_hold   = (state == ST_LOW) && !pin_rst_n && (low_cnt >= LOW_W'(FULL_MIN_CYC));

   // Count the low time; saturate so a long hold cannot wrap into a short one.
   // Saturating at the full limit keeps the counter to seven bits.
   always_ff @(posedge clk_sys_i) begin
      if (reset_i || pin_rst_n) begin
         low_cnt <= '0;
      end else if (low_cnt != LOW_W'(FULL_MIN_CYC)) begin
         low_cnt <= low_cnt + 1'b1;
      end
   end

   // A low pin always restarts classification, even while waiting.
   // Ready stays low through the wait, so an early start is refused, not queued.
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         state    <= ST_FULL_WAIT;
         wait_cnt <= CNT_W'(FULL_READY_CYCLES);
      end else if (!pin_rst_n) begin
         state    <= ST_LOW;
      end else begin
         unique case (state)
            ST_LOW: begin
               if (full_rel) begin
                  state    <= ST_FULL_WAIT;
                  wait_cnt <= CNT_W'(FULL_READY_CYCLES);
               end else if (part_rel) begin
                  state    <= ST_PART_WAIT;
                  wait_cnt <= CNT_W'(PART_READY_CYC);
               end else begin
                  state    <= ST_RUN;
               end
            end
            ST_PART_WAIT, ST_FULL_WAIT: begin
               if (wait_cnt <= CNT_W'(1)) begin
                  state <= ST_RUN;
               end
               wait_cnt <= wait_cnt - 1'b1;
            end
            ST_RUN: begin
               state <= ST_RUN;
            end
         endcase
      end
   end

   assign ready_o = (state == ST_RUN);

   // ------------------------------------------------------------
   // Strap latches, written only at a full reset release.
   // ------------------------------------------------------------
   rcl_cfg_t next_cfg;

   always_comb begin
      next_cfg         = CFG_LAT_RESET;
      next_cfg.hw_mode = (range_s != RANGE_SW_MODE);
      next_cfg.int_ref = ref_s;
      next_cfg.iface   = iface_s;
      // Burst, sequencer and checksum straps only mean something in hardware mode.
      if (next_cfg.hw_mode) begin
         next_cfg.burst = burst_s;
         next_cfg.seq   = seq_s;
         next_cfg.crc   = crc_s;
      end
   end

   // Held at defaults while a full-length pulse is low, caught at release.
   // Straps pass the same synchroniser as the reset pin, so both are seen together.
   always_ff @(posedge clk_sys_i) begin
      if (reset_i || full_hold) begin
         cfg_o <= CFG_LAT_RESET;
      end else if (full_rel) begin
         cfg_o <= next_cfg;
      end
   end

   // ------------------------------------------------------------
   // Software configuration register.
   // ------------------------------------------------------------
   logic [DATA_W-1:0] cfg_reg;
   logic              hit_wr;

   assign hit_wr = reg_wr_i && !cfg_o.hw_mode && ready_o && (reg_addr_i == ADDR_CFG);

   // A partial reset leaves this register alone; only a full one clears it.
   // Writes are dropped unless ready, so a write cannot race the clearing of a full reset.
   always_ff @(posedge clk_sys_i) begin
      if (reset_i || full_hold) begin
         cfg_reg <= CFG_RESET;
      end else if (hit_wr) begin
         cfg_reg <= reg_wdata_i;
      end
   end

   // Reads answer in the next cycle; hardware mode reads as zero and is flagged.
   // Unmapped addresses read as zero, so a probe by software does no harm.
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         reg_rdata_o   <= '0;
         reg_refused_o <= 1'b0;
      end else begin
         reg_refused_o <= cfg_o.hw_mode && (reg_rd_i || reg_wr_i);
         reg_rdata_o   <= '0;
         if (reg_rd_i && !cfg_o.hw_mode) begin
            if (reg_addr_i == ADDR_CFG) begin
               reg_rdata_o <= cfg_reg;
            end else if (reg_addr_i == ADDR_STAT) begin
               reg_rdata_o <= {3'h0, cfg_o.int_ref, cfg_o.iface, range_settled_o,
                               busy_o, ready_o, cfg_o.hw_mode};
            end
         end
      end
   end

   // ------------------------------------------------------------
   // Range: live from the pins in hardware mode, never latched.
   // ------------------------------------------------------------
   logic [CNT_W-1:0] settle_cnt;
   logic [1:0]       next_range;

   assign next_range = cfg_o.hw_mode ? range_s
                                     : cfg_reg[CFG_RANGE_LSB +: 2];

   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         range_o <= '0;
      end else begin
         range_o <= next_range;
      end
   end

   // Settling only flags readiness; the range itself switches at once.
   // A limitation: a new change while settling restarts the whole wait.
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         settle_cnt <= '0;
      end else if (next_range != range_o) begin
         settle_cnt <= CNT_W'(RANGE_SETTLE_CYCLES);
      end else if (settle_cnt != '0) begin
         settle_cnt <= settle_cnt - 1'b1;
      end
   end

   assign range_settled_o = (settle_cnt == '0);

   // ------------------------------------------------------------
   // Conversion timing and channel pair selection.
   // ------------------------------------------------------------
   logic [5:0] conv_cnt;
   logic       conv_rise;
   logic       conv_done;

   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         conv_d <= 1'b0;
      end else begin
         conv_d <= conv_s;
      end
   end

   assign conv_rise = conv_s && !conv_d && ready_o && !busy_o;
   assign conv_done = busy_o && (conv_cnt == 6'd1);

   // Any reset pin activity aborts the conversion, so its result is dropped.
   // A held start pin cannot retrigger: only a fresh rising edge is taken.
   always_ff @(posedge clk_sys_i) begin
      if (reset_i || !pin_rst_n) begin
         busy_o         <= 1'b0;
         conv_cnt       <= '0;
         result_valid_o <= 1'b0;
      end else begin
         result_valid_o <= conv_done;
         if (conv_rise) begin
            busy_o   <= 1'b1;
            conv_cnt <= 6'(CONV_CYC);
         end else if (busy_o) begin
            busy_o   <= !conv_done;
            conv_cnt <= conv_cnt - 1'b1;
         end
      end
   end

   // Pair pins are read at every reset release and at the end of busy.
   // In software mode the pins have no function and the register decides.
   always_ff @(posedge clk_sys_i) begin
      if (reset_i || full_hold) begin
         pair_sel_o <= '0;
      end else if (!cfg_o.hw_mode && !release_now) begin
         pair_sel_o <= cfg_reg[CFG_PAIR_LSB +: 3];
      end else if (release_now && (next_cfg.hw_mode || !full_rel) && cfg_o.hw_mode) begin
         pair_sel_o <= pair_s;
      end else if (full_rel && next_cfg.hw_mode) begin
         pair_sel_o <= pair_s;
      end else if (conv_done) begin
         pair_sel_o <= pair_s;
      end
   end

   // One pulse restarts sequencer, filter and converters on partial release.
   // Latched straps and the register are left alone by it.
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         reinit_o <= 1'b0;
      end else begin
         reinit_o <= part_rel;
      end
   end

   // ------------------------------------------------------------
   // Assertions.
   // ------------------------------------------------------------
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (reset_i);
   // Properties watch the synchronised pin, the same view the logic has.

   AST_PART_CLASS: assert property (part_rel |=> reinit_o && state == ST_PART_WAIT)
      else $error("Partial reset not classified.");
   AST_FULL_CLASS: assert property (full_rel |=> state == ST_FULL_WAIT && !reinit_o)
      else $error("Full reset not classified.");
   AST_SHORT_IGNORE: assert property (release_now && low_cnt < LOW_W'(PART_MIN_CYC)
      |=> state == ST_RUN && !reinit_o)
      else $error("Glitch on reset pin acted on.");
   AST_MODE_LATCH: assert property (full_rel |=> cfg_o.hw_mode == ($past(range_s) != 2'h0)
      && cfg_o.int_ref == $past(ref_s))
      else $error("Mode or reference latched wrongly.");
   AST_CFG_HOLD: assert property (!full_rel && !full_hold |=> $stable(cfg_o))
      else $error("Latched configuration changed without full reset.");
   AST_PART_KEEP: assert property (part_rel |=> $stable(cfg_reg) && $stable(cfg_o))
      else $error("Partial reset disturbed configuration.");
   AST_HW_REFUSE: assert property (cfg_o.hw_mode && reg_wr_i |=> $stable(cfg_reg)
      && reg_refused_o)
      else $error("Register access taken in hardware mode.");
   AST_PART_READY: assert property (part_rel |=> !ready_o [*5] ##1 !ready_o ##1 ready_o
      or !pin_rst_n)
      else $error("Ready timing after partial reset wrong.");
   AST_RANGE_LIVE: assert property (cfg_o.hw_mode && $stable(cfg_o) |=>
      range_o == $past(range_s))
      else $error("Range does not follow pins in hardware mode.");
   // A low reset pin is the only thing allowed to cut a conversion short.
   AST_BUSY_LEN: assert property ($rose(busy_o) |-> busy_o [*8] or ##[0:7] !pin_rst_n)
      else $error("Conversion ended too early.");
   AST_ABORT: assert property (busy_o && !pin_rst_n |=> !busy_o ##1 !result_valid_o)
      else $error("Aborted conversion kept running or gave a result.");
   AST_FULL_PAIR: assert property (full_rel && next_cfg.hw_mode |=>
      pair_sel_o == $past(pair_s))
      else $error("Pair pins not taken at full reset release.");

   COV_FULL: cover property (full_rel ##[1:100] ready_o);
   COV_PART: cover property (part_rel ##7 ready_o);
   COV_CONV: cover property (conv_rise ##[1:40] result_valid_o);
   COV_ABORT: cover property (busy_o ##1 !pin_rst_n);
   COV_REFUSE: cover property (reg_refused_o);

endmodule

/* include/rcl_pkg.sv */
package rcl_pkg;

   // ------------------------------------------------------------
   // Timing, all counts in cycles of the 50 MHz system clock.
   // ------------------------------------------------------------
   localparam int CLK_MHZ          = 50;
   localparam int PART_MIN_NS      = 40;
   localparam int PART_MAX_NS      = 500;
   localparam int FULL_MIN_NS      = 1200;
   localparam int PART_READY_NS    = 120;
   localparam int FULL_READY_US    = 15000;
   localparam int RANGE_SETTLE_US  = 120;
   localparam int CONV_NS          = 500;
   // A least time rounds up, a longest time rounds down.
   localparam int PART_MIN_CYC     = (PART_MIN_NS * CLK_MHZ + 999) / 1000;
   localparam int PART_MAX_CYC     = (PART_MAX_NS * CLK_MHZ) / 1000;
   localparam int FULL_MIN_CYC     = (FULL_MIN_NS * CLK_MHZ + 999) / 1000;
   localparam int PART_READY_CYC   = (PART_READY_NS * CLK_MHZ) / 1000;
   localparam int FULL_READY_CYC   = FULL_READY_US * CLK_MHZ;
   localparam int RANGE_SETTLE_CYC = RANGE_SETTLE_US * CLK_MHZ;
   localparam int CONV_CYC         = (CONV_NS * CLK_MHZ) / 1000;
   localparam int CNT_W            = 20;
   localparam int LOW_W            = 7;

   // ------------------------------------------------------------
   // Register port: 6-bit address, 9-bit data.
   // ------------------------------------------------------------
   localparam int          ADDR_W     = 6;
   localparam int          DATA_W     = 9;
   localparam logic [5:0]  ADDR_CFG   = 6'h02;
   localparam logic [5:0]  ADDR_STAT  = 6'h03;
   localparam logic [8:0]  CFG_RESET  = 9'h000;
   localparam int          CFG_PAIR_LSB  = 0;
   localparam int          CFG_BURST     = 3;
   localparam int          CFG_SEQ       = 4;
   localparam int          CFG_CRC       = 5;
   localparam int          CFG_RANGE_LSB = 6;
   localparam logic [1:0]  RANGE_SW_MODE = 2'h0;

   // Configuration caught at the release of a full reset.
   typedef struct packed {
      logic hw_mode;
      logic int_ref;
      logic iface;
      logic burst;
      logic seq;
      logic crc;
   } rcl_cfg_t;

   localparam rcl_cfg_t CFG_LAT_RESET = '0;

   typedef enum logic [1:0] {
      ST_RUN,
      ST_LOW,
      ST_PART_WAIT,
      ST_FULL_WAIT
   } rcl_state_t;

endpackage

/* dv/rcl_host_model.sv */
`timescale 1ns/1ps
// ------------------------------------------------------------
// Host controller model: reset pin, strap levels, conversion start.
// ------------------------------------------------------------
module rcl_host_model
   import rcl_pkg::*;
(
   input  wire logic       clk_sys_i,   // System clock.
   input  wire logic       busy_i,      // Conversion in progress.
   input  wire logic       ready_i,     // Conversion may start.
   input  wire logic       valid_i,     // Result kept pulse.
   output logic            rst_pin_n_o, // Reset pin, active low.
   output logic            ref_o,       // Reference strap.
   output logic [1:0]      range_o,     // Range and mode strap.
   output logic            iface_o,     // Interface strap.
   output logic            crc_o,       // Checksum strap.
   output logic            burst_o,     // Burst strap.
   output logic            seq_o,       // Sequencer strap.
   output logic [2:0]      pair_o,      // Channel pair pins.
   output logic            conv_o       // Conversion start.
);
   // Pins idle with reset released and no conversion requested.
   initial begin
      {rst_pin_n_o, ref_o, range_o, iface_o, crc_o, burst_o, seq_o, pair_o, conv_o} = 12'h800;
   end

   // Strap levels change together, just after an edge.
   task automatic set_straps(input logic r, input logic [1:0] g, input logic i, c, b, s,
                             input logic [2:0] p);
      @(posedge clk_sys_i);
      {ref_o, range_o, iface_o, crc_o, burst_o, seq_o, pair_o} <= {r, g, i, c, b, s, p};
   endtask

   // Ten cycles give a partial reset, seventy a full one.
   task automatic pulse_reset(input int cyc);
      @(posedge clk_sys_i);
      rst_pin_n_o <= 1'b0;
      repeat (cyc) @(posedge clk_sys_i);
      rst_pin_n_o <= 1'b1;
   endtask

   // The start and pair pins stay put for the whole window, well past the busy fall; reset drops at abort_at for ten cycles.
   task automatic convert(input logic [2:0] pair, input int abort_at,
                          output int busy_cyc, output int valid_cnt);
      int i;
      busy_cyc = 0;
      valid_cnt = 0;
      @(posedge clk_sys_i);
      pair_o <= pair;
      for (i = 0; i < 200 && ready_i !== 1'b1; i++) @(posedge clk_sys_i);
      conv_o <= 1'b1;
      for (i = 0; i < 80; i++) begin
         @(posedge clk_sys_i);
         if (i == abort_at) rst_pin_n_o <= 1'b0;
         if (i == abort_at + 10) rst_pin_n_o <= 1'b1;
         #1;
         busy_cyc += (busy_i === 1'b1);
         valid_cnt += (valid_i === 1'b1);
      end
      @(posedge clk_sys_i);
      conv_o <= 1'b0;
   endtask
endmodule

/* dv/rcl_reset_config_latch_test.sv */
`timescale 1ns/1ps
// ------------------------------------------------------------
// Self-checking bench with shortened full-reset and settle counts.
// ------------------------------------------------------------
module rcl_reset_config_latch_test
   import rcl_pkg::*;
();
   logic              clk_sys_i = 1'b0;
   logic              reset_i   = 1'b1;
   logic [ADDR_W-1:0] reg_addr  = '0;
   logic [DATA_W-1:0] reg_wdata = '0;
   logic              reg_wr    = 1'b0;
   logic              reg_rd    = 1'b0;
   wire logic         rst_pin_n, ref_s, iface_s, crc_s, burst_s, seq_s, conv_s;
   wire logic [1:0]   rng_s;
   wire logic [2:0]   pair_s;
   logic [DATA_W-1:0] rdata;
   logic              refused, settled, reinit, ready, busy, rvalid;
   rcl_cfg_t          cfg;
   logic [1:0]        range;
   logic [2:0]        pair_sel;
   int                err_total = 0;
   int                checks_done = 0;
   int                reinit_cnt = 0;
   int                bc_w [3] = '{3, 25, 40};
   logic [31:0]       seed = 32'h91d21213;
   logic              s_ref, s_iface, s_crc, s_burst, s_seq;
   logic [1:0]        s_rng;
   logic [2:0]        s_pair;

   rcl_reset_config_latch #(.FULL_READY_CYCLES(50), .RANGE_SETTLE_CYCLES(20)) uut (
      .clk_sys_i(clk_sys_i), .reset_i(reset_i), .reset_pin_n_i(rst_pin_n),
      .ref_select_strap_i(ref_s), .range_mode_strap_i(rng_s), .iface_type_strap_i(iface_s),
      .crc_strap_i(crc_s), .wr_burst_i(burst_s), .seq_enable_strap_i(seq_s),
      .pair_select_pins_i(pair_s), .conv_start_i(conv_s), .reg_addr_i(reg_addr),
      .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(rdata),
      .reg_refused_o(refused), .cfg_o(cfg), .range_o(range), .range_settled_o(settled),
      .pair_sel_o(pair_sel), .reinit_o(reinit), .ready_o(ready), .busy_o(busy),
      .result_valid_o(rvalid));

   rcl_host_model host (
      .clk_sys_i(clk_sys_i), .busy_i(busy), .ready_i(ready), .valid_i(rvalid),
      .rst_pin_n_o(rst_pin_n), .ref_o(ref_s), .range_o(rng_s), .iface_o(iface_s),
      .crc_o(crc_s), .burst_o(burst_s), .seq_o(seq_s), .pair_o(pair_s), .conv_o(conv_s));

   // Clock, a hang limit, and a tally of reinitialise pulses.
   always #10 clk_sys_i = ~clk_sys_i;
   initial begin
      #400000;
      err_total++;
      final_report();
   end
   always @(posedge clk_sys_i) if (reinit === 1'b1) reinit_cnt <= reinit_cnt + 1;

   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   // Software mode keeps the hardware-only straps out of the latch.
   function automatic rcl_cfg_t exp_cfg();
      logic hw;
      hw = (s_rng != RANGE_SW_MODE);
      return '{hw, s_ref, s_iface, hw & s_burst, hw & s_seq, hw & s_crc};
   endfunction

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_total++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic final_report();
      if (err_total == 0 && checks_done > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   task automatic wait_ready(input int lim);
      int i;
      for (i = 0; i < lim && ready !== 1'b1; i++) @(posedge clk_sys_i);
      if (ready !== 1'b1) begin
         err_total++;
         final_report();
      end
   endtask

   // One register strobe; read data and refusal are taken in the next cycle.
   task automatic reg_op(input logic wr, input logic [ADDR_W-1:0] a,
                         input logic [DATA_W-1:0] d, output logic [DATA_W-1:0] q,
                         output logic rf);
      @(posedge clk_sys_i);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= wr;
      reg_rd <= ~wr;
      @(posedge clk_sys_i);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      #1;
      q = rdata;
      rf = refused;
   endtask

   // Full reset with random straps; a new configuration needs one.
   task automatic full_cfg(input logic [1:0] rng);
      logic [31:0] v;
      v = xs();
      s_rng = rng;
      {s_ref, s_iface, s_crc, s_burst, s_seq, s_pair} = v[7:0];
      host.set_straps(s_ref, s_rng, s_iface, s_crc, s_burst, s_seq, s_pair);
      host.pulse_reset(70);
      repeat (5) @(posedge clk_sys_i);
      #1;
      chk(cfg, exp_cfg());
      if (rng != RANGE_SW_MODE) chk(pair_sel, s_pair);
      repeat (35) @(posedge clk_sys_i);
      #1;
      chk(ready, 1'b0);
      wait_ready(100);
   endtask

   // Main sequence: hardware mode first, then software mode.
   initial begin
      logic [DATA_W-1:0] q, w;
      logic rf;
      logic [2:0] p;
      int bc, vc, r0, n;
      rcl_cfg_t keep;
      repeat (4) @(posedge clk_sys_i);
      reset_i <= 1'b0;
      #1;
      chk(cfg, CFG_LAT_RESET);
      full_cfg(2'(1 + xs() % 3));
      keep = cfg;
      host.set_straps(~s_ref, s_rng, ~s_iface, ~s_crc, ~s_burst, ~s_seq, s_pair);
      repeat (5) @(posedge clk_sys_i);
      chk(cfg, keep);
      s_rng = 2'(s_rng % 3 + 1);
      host.set_straps(~s_ref, s_rng, ~s_iface, ~s_crc, ~s_burst, ~s_seq, s_pair);
      repeat (4) @(posedge clk_sys_i);
      #1;
      chk(range, s_rng);
      chk(settled, 1'b0);
      chk(cfg, keep);
      repeat (30) @(posedge clk_sys_i);
      chk(settled, 1'b1);
      reg_op(1'b1, ADDR_CFG, 9'(xs()), q, rf);
      chk(rf, 1'b1);
      reg_op(1'b0, ADDR_STAT, '0, q, rf);
      chk({q, rf}, 10'h001);
      foreach (bc_w[i]) begin
         p = 3'(xs());
         host.set_straps(~s_ref, s_rng, ~s_iface, ~s_crc, ~s_burst, ~s_seq, p);
         r0 = reinit_cnt;
         host.pulse_reset(bc_w[i]);
         // The pin needs two sync cycles and a classify cycle before ready drops.
         repeat (4) @(posedge clk_sys_i);
         for (n = 0; n < 12 && ready !== 1'b1; n++) @(posedge clk_sys_i);
         chk(ready, 1'b1);
         chk(reinit_cnt - r0, 1);
         chk(cfg, keep);
         chk(pair_sel, p);
      end
      r0 = reinit_cnt;
      host.pulse_reset(1);
      repeat (8) @(posedge clk_sys_i);
      chk(reinit_cnt - r0, 0);
      chk(ready, 1'b1);
      repeat (2) begin
         p = 3'(xs());
         host.convert(p, -100, bc, vc);
         chk(bc, 25);
         chk(vc, 1);
         chk(pair_sel, p);
      end
      r0 = reinit_cnt;
      host.convert(~p, 5, bc, vc);
      chk(bc < 25, 1'b1);
      chk(vc, 0);
      chk(reinit_cnt - r0, 1);
      full_cfg(RANGE_SW_MODE);
      reg_op(1'b0, ADDR_CFG, '0, q, rf);
      chk(q, CFG_RESET);
      w = 9'(xs());
      reg_op(1'b1, ADDR_CFG, w, q, rf);
      reg_op(1'b0, ADDR_CFG, '0, q, rf);
      chk(q, w);
      reg_op(1'b0, ADDR_STAT, '0, q, rf);
      chk({q[8:4], q[2:0], rf}, {3'h0, s_ref, s_iface, 3'b010, 1'b0});
      reg_op(1'b0, 6'h3f, '0, q, rf);
      chk(q, 9'h000);
      host.pulse_reset(10);
      repeat (4) @(posedge clk_sys_i);
      wait_ready(12);
      reg_op(1'b0, ADDR_CFG, '0, q, rf);
      chk(q, w);
      host.convert(3'h0, -100, bc, vc);
      chk(vc, 1);
      final_report();
   end

endmodule
